// >>> pm_link_slave.sv
// power-management bus slave: byte framing, command decode, faults
`timescale 1ns/1ps
// Summary of operation
// - words go low byte first; each byte moves msb first
// - extension prefix byte is followed by a second code byte of any value
// - slave never drives scl; it only holds it low during low phase
// - hold scl low while receive buffer full or read data not ready
// - total clock holding capped at the timeout; then release and go idle
// - scl low past timeout aborts transfer, frees lines, accepts new start
// - acknowledge own address and the general call address
// - same behaviour at standard and fast bus rates
// - no checksum byte generated or checked, no busy signalling
// - start or stop mid-byte drops the partial byte without fault
// - early stop is no error; only pending transmit data is flushed
// - surplus written bytes are nacked, transfer discarded, fault set
// - surplus reads return all-ones bytes and set the fault
// - read bit in first address: ack it, nack rest, send ones, fault
// - unknown command code: nack it and data, discard, set fault
// - reserved status bits ignore writes and read as zero
// - write to read-only command: nack data, discard, set fault
// - read from write-only command: send all-ones bytes, set fault
// - receiver acks each byte low; master nacks last read byte
// - own address is base plus three-bit select pin value
// - commands execute only when the closing stop arrives
module pm_link_slave
	import pmbus_slave_pkg::*;
#(
	parameter int unsigned TO_CYC = pmbus_slave_pkg::TIMEOUT_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	input  wire logic [2:0] addr_sel,
	output logic      [7:0] cmd_code,
	output logic      [7:0] cmd_ext_code,
	output logic            cmd_ext,
	input  wire logic       cmd_known,
	input  wire logic [7:0] cmd_wr_len,
	input  wire logic [7:0] cmd_rd_len,
	output logic      [7:0] wr_data,
	output logic            wr_valid,
	input  wire logic       wr_ready,
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_valid,
	output logic            rd_ready,
	output logic            cmd_done,
	output logic            cmd_abort,
	output logic            tx_flush,
	input  wire logic       fault_clr,
	output logic            comm_fault_flag,
	output logic      [7:0] status_summary
);
	import pmbus_slave_pkg::*;

	state_e           state_q;
	logic [2:0]       scl_sy_q;
	logic [2:0]       sda_sy_q;
	logic [2:0]       asel_m_q;
	logic [2:0]       asel_s_q;
	logic [3:0]       bitcnt_q;
	logic [7:0]       sr_q;
	logic [7:0]       wr_cnt_q;
	logic [7:0]       rd_cnt_q;
	logic [CNT_W-1:0] low_cnt_q;
	logic [CNT_W-1:0] hold_cnt_q;
	logic [6:0]       own_addr;
	logic [7:0]       byte_in;
	logic             scl_s;
	logic             sda_s;
	logic             scl_rise;
	logic             scl_fall;
	logic             start_det;
	logic             stop_det;
	logic             timeout;
	logic             byte_done_q;
	logic             dec_q;
	logic             drv_q;
	logic             ack_q;
	logic             need_push_q;
	logic             push_q;
	logic             addr_phase_q;
	logic             addressed_q;
	logic             rd_dir_q;
	logic             rd_seen_q;
	logic             cmd_seen_q;
	logic             ext_pend_q;
	logic             fault_txn_q;
	logic             ff_mode_q;
	logic             loaded_q;
	logic             mack_q;
	logic             fault_pulse_q;
	logic             fifo_in_ready;

	// open-drain lines only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign status_summary = 8'(comm_fault_flag) << COMM_FAULT_BIT;

	// two-flop synchronisers, third stage only for edge finding
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			scl_sy_q <= 3'h7;
			sda_sy_q <= 3'h7;
			asel_m_q <= 3'h0;
			asel_s_q <= 3'h0;
		end else begin
			scl_sy_q <= {scl_sy_q[1:0], scl_i};
			sda_sy_q <= {sda_sy_q[1:0], sda_i};
			asel_m_q <= addr_sel;
			asel_s_q <= asel_m_q;
		end
	end

	// 40 MHz sampling gives 100 cycles per bit even at fast rate
	assign scl_s     = scl_sy_q[1];
	assign sda_s     = sda_sy_q[1];
	assign scl_rise  = scl_sy_q[1] & ~scl_sy_q[2];
	assign scl_fall  = ~scl_sy_q[1] & scl_sy_q[2];
	assign start_det = scl_sy_q[1] & scl_sy_q[2] & sda_sy_q[2] & ~sda_s;
	assign stop_det  = scl_sy_q[1] & scl_sy_q[2] & ~sda_sy_q[2] & sda_s;
	assign own_addr  = ADDR_BASE | {4'h0, asel_s_q};
	assign byte_in   = {sr_q[6:0], sda_s};

	// a held-low clock, by anyone, ends the transfer at the limit
	assign timeout = (low_cnt_q == CNT_W'(TO_CYC - 1)) ||
		(hold_cnt_q == CNT_W'(TO_CYC - 1));

	// low-phase length and accumulated own stretch, idle resets both
	always_ff @(posedge sys_clk) begin
		if (!nrst || state_q == ST_IDLE) begin
			low_cnt_q  <= '0;
			hold_cnt_q <= '0;
		end else begin
			low_cnt_q  <= scl_s ? '0 : low_cnt_q + 1'b1;
			if (scl_oe) begin
				hold_cnt_q <= hold_cnt_q + 1'b1;
			end
		end
	end

	// sticky fault flag; a new fault beats a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			comm_fault_flag <= FAULT_RST;
		end else if (fault_pulse_q) begin
			comm_fault_flag <= 1'b1;
		end else if (fault_clr) begin
			comm_fault_flag <= 1'b0;
		end
	end

	// protocol engine: framing, ack decisions, stretching, fill data
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			{scl_oe, sda_oe, rd_ready, push_q} <= 4'h0;
			{cmd_done, cmd_abort, tx_flush} <= 3'h0;
			{byte_done_q, dec_q, drv_q, ack_q, need_push_q} <= 5'h0;
			{addr_phase_q, addressed_q, rd_dir_q, rd_seen_q} <= 4'h0;
			{cmd_seen_q, ext_pend_q, fault_txn_q, ff_mode_q} <= 4'h0;
			{loaded_q, mack_q, fault_pulse_q, cmd_ext} <= 4'h0;
			bitcnt_q     <= 4'h0;
			sr_q         <= 8'h00;
			wr_cnt_q     <= 8'h00;
			rd_cnt_q     <= 8'h00;
			cmd_code     <= 8'h00;
			cmd_ext_code <= 8'h00;
		end else begin
			{rd_ready, push_q, cmd_done, cmd_abort} <= 4'h0;
			{tx_flush, byte_done_q, fault_pulse_q} <= 3'h0;
			if (timeout) begin
				state_q   <= ST_IDLE;
				scl_oe    <= 1'b0;
				sda_oe    <= 1'b0;
				cmd_abort <= 1'b1;
			end else if (stop_det) begin
				// writes commit here, never earlier
				// a stop after a timeout finds idle and must not replay
				cmd_done  <= (state_q != ST_IDLE) & cmd_seen_q & ~rd_seen_q
					& ~fault_txn_q;
				cmd_abort <= (state_q != ST_IDLE) & fault_txn_q;
				tx_flush  <= (state_q != ST_IDLE) & addressed_q
					& rd_dir_q;
				state_q   <= ST_IDLE;
				bitcnt_q  <= 4'h0;
				scl_oe    <= 1'b0;
				sda_oe    <= 1'b0;
			end else if (start_det) begin
				if (state_q == ST_IDLE) begin
					{cmd_seen_q, ext_pend_q, fault_txn_q} <= 3'h0;
					{rd_seen_q, ff_mode_q} <= 2'h0;
					wr_cnt_q <= 8'h00;
				end
				state_q      <= ST_RX;
				addr_phase_q <= 1'b1;
				bitcnt_q     <= 4'h0;
				scl_oe       <= 1'b0;
				sda_oe       <= 1'b0;
			end else begin
				case (state_q)
					ST_RX: begin
						if (scl_rise) begin
							sr_q <= byte_in;
							if (bitcnt_q == LAST_BIT) begin
								bitcnt_q    <= 4'h0;
								byte_done_q <= 1'b1;
								{dec_q, drv_q} <= 2'h0;
								state_q     <= ST_RACK;
								if (!addr_phase_q && ext_pend_q) begin
									cmd_ext_code <= byte_in;
								end else if (!addr_phase_q && !cmd_seen_q) begin
									cmd_code     <= byte_in;
									cmd_ext      <= (byte_in == EXT_PREFIX);
									cmd_ext_code <= 8'h00;
								end
							end else begin
								bitcnt_q <= bitcnt_q + 1'b1;
							end
						end
					end
					ST_RACK: begin
						if (byte_done_q) begin
							dec_q <= 1'b1;
							if (addr_phase_q) begin
								addr_phase_q <= 1'b0;
								if (sr_q[7:1] == own_addr ||
									(sr_q[7:1] == GCALL_ADDR && !sr_q[0])) begin
									ack_q       <= 1'b1;
									addressed_q <= 1'b1;
									rd_dir_q    <= sr_q[0];
									if (sr_q[0]) begin
										rd_seen_q <= 1'b1;
										rd_cnt_q  <= 8'h00;
										// read before any command is a content fault
										ff_mode_q <= ~cmd_seen_q | fault_txn_q;
										if (!cmd_seen_q) begin
											fault_txn_q   <= 1'b1;
											fault_pulse_q <= 1'b1;
										end
									end
								end else begin
									ack_q       <= 1'b0;
									addressed_q <= 1'b0;
								end
							end else if (!cmd_seen_q && !fault_txn_q &&
								sr_q == EXT_PREFIX) begin
								ack_q      <= 1'b1;
								cmd_seen_q <= 1'b1;
								ext_pend_q <= 1'b1;
							end else if (!cmd_seen_q || ext_pend_q) begin
								cmd_seen_q <= 1'b1;
								ext_pend_q <= 1'b0;
								ack_q      <= cmd_known & ~fault_txn_q;
								if (!cmd_known && !fault_txn_q) begin
									fault_txn_q   <= 1'b1;
									fault_pulse_q <= 1'b1;
								end
							end else if (fault_txn_q || wr_cnt_q >= cmd_wr_len) begin
								// surplus or read-only target; no checksum byte expected
								ack_q         <= 1'b0;
								fault_txn_q   <= 1'b1;
								fault_pulse_q <= ~fault_txn_q;
							end else begin
								ack_q       <= 1'b1;
								need_push_q <= 1'b1;
								wr_cnt_q    <= wr_cnt_q + 1'b1;
							end
						end else if (dec_q && !drv_q && !scl_s) begin
							// stall the master rather than overflow the buffer
							if (need_push_q && !fifo_in_ready) begin
								scl_oe <= 1'b1;
							end else begin
								scl_oe      <= 1'b0;
								sda_oe      <= ack_q;
								drv_q       <= 1'b1;
								push_q      <= need_push_q;
								need_push_q <= 1'b0;
							end
						end else if (drv_q && scl_fall) begin
							sda_oe   <= 1'b0;
							loaded_q <= 1'b0;
							if (!addressed_q) begin
								state_q <= ST_WAIT;
							end else if (rd_dir_q) begin
								state_q <= ST_TX;
							end else begin
								state_q <= ST_RX;
							end
						end
					end
					ST_TX: begin
						if (!loaded_q) begin
							if (ff_mode_q || rd_cnt_q >= cmd_rd_len) begin
								sr_q     <= FILL_BYTE;
								loaded_q <= 1'b1;
								scl_oe   <= 1'b0;
								sda_oe   <= 1'b0;
								if (!ff_mode_q) begin
									ff_mode_q     <= 1'b1;
									fault_pulse_q <= 1'b1;
								end
							end else if (rd_valid) begin
								sr_q     <= rd_data;
								rd_ready <= 1'b1;
								loaded_q <= 1'b1;
								scl_oe   <= 1'b0;
								sda_oe   <= ~rd_data[7];
								rd_cnt_q <= rd_cnt_q + 1'b1;
							end else begin
								scl_oe <= 1'b1;
							end
						end else if (scl_fall) begin
							if (bitcnt_q == LAST_BIT) begin
								bitcnt_q <= 4'h0;
								sda_oe   <= 1'b0;
								state_q  <= ST_TACK;
							end else begin
								bitcnt_q <= bitcnt_q + 1'b1;
								sr_q     <= {sr_q[6:0], 1'b1};
								sda_oe   <= ~sr_q[6];
							end
						end
					end
					ST_TACK: begin
						if (scl_rise) begin
							mack_q <= ~sda_s;
						end else if (scl_fall) begin
							loaded_q <= 1'b0;
							state_q  <= mack_q ? ST_TX : ST_WAIT;
						end
					end
					ST_WAIT, ST_IDLE: begin
						sda_oe <= 1'b0;
						scl_oe <= 1'b0;
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	byte_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.flush     (cmd_abort),
		.in_data   (sr_q),
		.in_valid  (push_q),
		.in_ready  (fifo_in_ready),
		.out_data  (wr_data),
		.out_valid (wr_valid),
		.out_ready (wr_ready)
	);

	// checks on the engine
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	AST_SCL_HOLD_LOW: assert property (
		$rose(scl_oe) |-> !scl_s)
		else $error("scl hold started while scl high");
	AST_STRETCH_FULL: assert property (
		(state_q == ST_RACK && dec_q && !drv_q && need_push_q
			&& !fifo_in_ready && !scl_s && !timeout && !start_det
			&& !stop_det) |=> scl_oe)
		else $error("no stretch while receive buffer full");
	AST_TIMEOUT_FREE: assert property (
		timeout |=> (state_q == ST_IDLE) && !scl_oe && !sda_oe
			&& cmd_abort)
		else $error("timeout did not release bus");
	AST_GCALL_ACK: assert property (
		(byte_done_q && addr_phase_q && sr_q == 8'h00 && state_q == ST_RACK
			&& !timeout && !start_det && !stop_det) |=> ack_q)
		else $error("general call not acknowledged");
	AST_PARTIAL_NOFAULT: assert property (
		(start_det || stop_det) |=> bitcnt_q == 4'h0 && !fault_pulse_q)
		else $error("partial byte raised fault");
	AST_NACK_RELEASE: assert property (
		(state_q == ST_RACK && drv_q && !ack_q) |-> !sda_oe)
		else $error("sda driven for a nack");
	AST_FILL_ONES: assert property (
		(state_q == ST_TX && loaded_q && sr_q == FILL_BYTE
			&& bitcnt_q == 4'h0) |-> !sda_oe)
		else $error("fill byte bit driven low");
	AST_FAULT_WINS: assert property (
		(fault_pulse_q && fault_clr) |=> comm_fault_flag)
		else $error("fault lost against clear");
	AST_FAULT_STICKY: assert property (
		(comm_fault_flag && !fault_clr) |=> comm_fault_flag)
		else $error("fault flag dropped without clear");
	AST_DONE_AT_STOP: assert property (
		cmd_done |-> $past(stop_det))
		else $error("command executed without stop");

	COV_WRITE_DONE: cover property (cmd_done);
	COV_STRETCH: cover property (scl_oe ##1 !scl_oe);
	COV_FILL_READ: cover property (state_q == ST_TX && ff_mode_q);
	COV_TIMEOUT: cover property (timeout);
endmodule

// >>> pmbus_slave_pkg.sv
// constants shared by the power-management bus slave and its receive fifo
package pmbus_slave_pkg;
	// core clock and bus timeout
	localparam int unsigned CLK_HZ      = 40_000_000;
	localparam int unsigned TIMEOUT_MS  = 25;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned CNT_W       = 20;

	// addressing and command codes
	localparam logic [6:0] ADDR_BASE   = 7'h58;
	localparam logic [6:0] GCALL_ADDR  = 7'h00;
	localparam logic [7:0] EXT_PREFIX  = 8'hFE;
	localparam logic [7:0] FILL_BYTE   = 8'hFF;
	localparam logic [3:0] LAST_BIT    = 4'h7;

	// summary status byte layout
	localparam int unsigned COMM_FAULT_BIT = 1;
	localparam logic        FAULT_RST      = 1'b0;

	// receive buffer shape
	localparam int unsigned FIFO_WIDTH = 8;
	localparam int unsigned FIFO_DEPTH = 32;

	// protocol engine states
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_RX   = 6'b000010,
		ST_RACK = 6'b000100,
		ST_TX   = 6'b001000,
		ST_TACK = 6'b010000,
		ST_WAIT = 6'b100000
	} state_e;
endpackage

// >>> byte_fifo.sv
// synchronous fifo with registered full and empty flags
`timescale 1ns/1ps
module byte_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic [AW:0]      count_d;
	logic             full_q;
	logic             empty_q;
	logic             push;
	logic             pop;

	assign push      = in_valid & ~full_q;
	assign pop       = out_ready & ~empty_q;
	assign in_ready  = ~full_q;
	assign out_valid = ~empty_q;
	assign out_data  = mem[rd_ptr_q];

	// occupancy after this cycle's push and pop
	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	// storage array needs no reset
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	// pointers and flags; flags registered so ports come from flops
	always_ff @(posedge sys_clk) begin
		if (!nrst || flush) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
			full_q   <= 1'b0;
			empty_q  <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			count_q <= count_d;
			full_q  <= (count_d == (AW+1)'(DEPTH));
			empty_q <= (count_d == '0);
		end
	end
endmodule

// >>> pm_master_model.sv
// bus master model: drives clock and data through open-drain pulls
`timescale 1ns/1ps
module pm_master_model (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_pull,
	output logic      sda_pull
);
	int half_ns = 1250;

	// both lines released at time zero so the pull-ups win
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end

	// one clock: data set mid-low, sampled mid-high
	// waiting for the wire to go high lets the slave stretch
	task automatic bit_cyc(input logic out_v, output logic in_v);
		#(half_ns / 2);
		sda_pull = ~out_v;
		#(half_ns / 2);
		scl_pull = 1'b0;
		wait (scl === 1'b1);
		#(half_ns / 2);
		in_v = sda;
		#(half_ns / 2);
		scl_pull = 1'b1;
	endtask

	// start or repeated start: data falls while the clock is high
	task automatic start();
		#(half_ns / 2);
		sda_pull = 1'b0;
		#(half_ns / 2);
		scl_pull = 1'b0;
		wait (scl === 1'b1);
		#(half_ns);
		sda_pull = 1'b1;
		#(half_ns);
		scl_pull = 1'b1;
	endtask

	// stop: data rises while the clock is high, both lines left free
	task automatic stop();
		#(half_ns / 2);
		sda_pull = 1'b1;
		#(half_ns / 2);
		scl_pull = 1'b0;
		wait (scl === 1'b1);
		#(half_ns);
		sda_pull = 1'b0;
		#(half_ns);
	endtask

	// byte out msb first, then sample the receiver's answer bit
	task automatic wr(input logic [7:0] b, output logic ack);
		logic x;
		for (int i = 7; i >= 0; i--)
			bit_cyc(b[i], x);
		bit_cyc(1'b1, ack);
	endtask

	// byte in msb first; a high answer marks the final byte
	task automatic rd(input logic last, output logic [7:0] b);
		logic x;
		for (int i = 7; i >= 0; i--)
			bit_cyc(1'b1, b[i]);
		bit_cyc(last, x);
	endtask
endmodule

// >>> pm_link_slave_bench.sv
// self-checking bench for the power-management bus slave
`timescale 1ns/1ps
module pm_link_slave_bench;
	import pmbus_slave_pkg::*;
	localparam int unsigned TO       = 2000;
	localparam logic [2:0]  EV_DONE  = 3'b100;
	localparam logic [2:0]  EV_ABORT = 3'b010;
	localparam logic [2:0]  EV_FLUSH = 3'b001;
	logic       sys_clk, nrst, scl_pull, sda_pull, scl_oe, sda_oe;
	logic       cmd_ext, cmd_known, wr_valid, wr_ready, rd_valid;
	logic       rd_ready, cmd_done, cmd_abort, tx_flush, fault_clr;
	logic       comm_fault_flag, lax, pop_en;
	logic [2:0] addr_sel, exp_ev;
	logic [7:0] cmd_code, cmd_ext_code, cmd_wr_len, cmd_rd_len;
	logic [7:0] wr_data, rd_data, status_summary, d0;
	logic [6:0] own;
	wire        scl_w, sda_w;
	logic [7:0] wq[$], rdq[$];
	logic [2:0] evq[$];
	int         fails, tests_run, cyc, k;
	integer     seed;

	// open-drain wires: pulled up unless some party pulls low
	assign scl_w = ~(scl_pull | scl_oe);
	assign sda_w = ~(sda_pull | sda_oe);

	// core's command table: {known, write length, read length}
	function automatic logic [16:0] look(input logic [7:0] c,
			input logic e, input logic [7:0] x);
		if (e)
			return (x == 8'h41) ? {1'b1, 8'h02, 8'h02} : 17'h00000;
		case (c)
			8'h21: return {1'b1, 8'h02, 8'h02};
			8'h01: return {1'b1, 8'h01, 8'h01};
			8'h03: return {1'b1, 8'h00, 8'h00};
			8'h88: return {1'b1, 8'h00, 8'h02};
			8'h10: return {1'b1, 8'h01, 8'h00};
			8'hD0: return {1'b1, 8'h28, 8'h00};
			default: return 17'h00000;
		endcase
	endfunction
	assign {cmd_known, cmd_wr_len, cmd_rd_len} =
		look(cmd_code, cmd_ext, cmd_ext_code);

	pm_link_slave #(.TO_CYC(TO)) dut (
		.sys_clk, .nrst, .scl_i(scl_w), .scl_o(), .scl_oe,
		.sda_i(sda_w), .sda_o(), .sda_oe, .addr_sel, .cmd_code,
		.cmd_ext_code, .cmd_ext, .cmd_known, .cmd_wr_len, .cmd_rd_len,
		.wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid, .rd_ready,
		.cmd_done, .cmd_abort, .tx_flush, .fault_clr, .comm_fault_flag,
		.status_summary
	);

	pm_master_model m (.scl(scl_w), .sda(sda_w), .scl_pull, .sda_pull);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// core side: read bytes staged in a queue, write-side pops throttled at random
	always @(posedge sys_clk) begin
		#1;
		if (tx_flush === 1'b1)
			rdq.delete();
		else if (rd_ready === 1'b1 && rdq.size() > 0)
			void'(rdq.pop_front());
		rd_valid = rdq.size() > 0;
		rd_data = (rdq.size() > 0) ? rdq[0] : 8'h00;
		wr_ready = pop_en & 1'($random(seed));
	end

	// watcher: pulses and popped words against the oldest note
	always @(posedge sys_clk) begin
		// nothing is looked at while reset still holds the outputs unknown
		if (nrst === 1'b1 && !lax &&
			{cmd_done, cmd_abort, tx_flush} !== 3'b000) begin
			exp_ev = (evq.size() > 0) ? evq.pop_front() : 3'b000;
			chk("event", {5'h00, exp_ev}, {5'h00, cmd_done, cmd_abort, tx_flush});
		end
		if ((wr_valid & wr_ready) !== 1'b0) begin
			d0 = (wq.size() > 0) ? wq.pop_front() : 8'h00;
			chk("wr_data", d0, wr_data);
		end
	end

	// hang guard about a quarter beyond the expected run length
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 95000) begin
			fails++;
			end_sim();
		end
	end

	task automatic chk(input string n, input logic [7:0] e,
			input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wb(input logic [7:0] b, input logic ea);
		logic a;
		m.wr(b, a);
		chk("ack", {7'h00, ea}, {7'h00, a});
	endtask

	task automatic rb(input logic [7:0] e, input logic last);
		logic [7:0] g;
		m.rd(last, g);
		chk("rd_byte", e, g);
	endtask

	// random data bytes, each noted for the watcher before it is sent
	task automatic wd(input int n);
		logic [7:0] d;
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			wq.push_back(d);
			wb(d, 1'b0);
		end
	endtask

	task automatic settle();
		repeat (20) @(posedge sys_clk);
		chk("events_left", 8'h00, 8'(evq.size()));
		chk("words_left", 8'h00, 8'(wq.size()));
	endtask

	// fault seen, summary bit one only, then cleared by software
	task automatic flt();
		settle();
		chk("flag", 8'h01, {7'h00, comm_fault_flag});
		chk("summary", 8'h02, status_summary);
		@(posedge sys_clk);
		#1 fault_clr = 1'b1;
		@(posedge sys_clk);
		#1 fault_clr = 1'b0;
		@(posedge sys_clk);
		#1 chk("flag_clr", 8'h00, {7'h00, comm_fault_flag});
		rdq.delete();
		lax = 1'b0;
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		seed = 32'hC978ADAB;
		{nrst, fault_clr, lax, pop_en, wr_ready, rd_valid} = 6'h04;
		rd_data = 8'h00;
		addr_sel = 3'($random(seed));
		own = ADDR_BASE | {4'h0, addr_sel};
		repeat (4) @(posedge sys_clk);
		#1 nrst = 1'b1;
		repeat (6) @(posedge sys_clk);
		// two-byte write, then a read stopped after one byte
		m.start();
		wb({own, 1'b0}, 1'b0);
		wb(8'h21, 1'b0);
		wd(2);
		evq.push_back(EV_DONE);
		m.stop();
		settle();
		m.start();
		wb({own, 1'b0}, 1'b0);
		wb(8'h21, 1'b0);
		d0 = 8'($random(seed));
		rdq.push_back(d0);
		rdq.push_back(8'hA5);
		m.start();
		wb({own, 1'b1}, 1'b0);
		rb(d0, 1'b1);
		evq.push_back(EV_FLUSH);
		m.stop();
		settle();
		// extended code, send command, foreign address
		m.start();
		wb({own, 1'b0}, 1'b0);
		wb(EXT_PREFIX, 1'b0);
		wb(8'h41, 1'b0);
		wd(2);
		evq.push_back(EV_DONE);
		m.stop();
		settle();
		chk("ext_code", 8'h41, cmd_ext_code);
		m.start();
		wb({own, 1'b0}, 1'b0);
		wb(8'h03, 1'b0);
		evq.push_back(EV_DONE);
		m.stop();
		settle();
		m.start();
		wb({7'h50, 1'b0}, 1'b1);
		m.stop();
		settle();
		// half byte then repeated start: partial byte dropped quietly
		m.start();
		wb({own, 1'b0}, 1'b0);
		for (int i = 0; i < 4; i++)
			m.bit_cyc(1'b0, d0[0]);
		m.start();
		wb({own, 1'b0}, 1'b0);
		wb(8'h01, 1'b0);
		wd(1);
		evq.push_back(EV_DONE);
		m.stop();
		settle();
		chk("flag", 8'h00, {7'h00, comm_fault_flag});
		// faults: unknown code, surplus byte, write to read-only
		m.start();
		wb({own, 1'b0}, 1'b0);
		wb(8'h77, 1'b1);
		wb(8'h5A, 1'b1);
		evq.push_back(EV_ABORT);
		m.stop();
		flt();
		m.start();
		wb({own, 1'b0}, 1'b0);
		wb(8'h01, 1'b0);
		wd(1);
		wb(8'h3C, 1'b1);
		evq.push_back(EV_ABORT);
		m.stop();
		flt();
		m.start();
		wb({own, 1'b0}, 1'b0);
		wb(8'h88, 1'b0);
		wb(8'hC3, 1'b1);
		evq.push_back(EV_ABORT);
		m.stop();
		flt();
		// faults on reads: too many, write-only, read bit first
		lax = 1'b1;
		m.start();
		wb({own, 1'b0}, 1'b0);
		wb(8'h01, 1'b0);
		rdq.push_back(8'h96);
		m.start();
		wb({own, 1'b1}, 1'b0);
		rb(8'h96, 1'b0);
		rb(FILL_BYTE, 1'b0);
		rb(FILL_BYTE, 1'b1);
		m.stop();
		flt();
		lax = 1'b1;
		m.start();
		wb({own, 1'b0}, 1'b0);
		wb(8'h10, 1'b0);
		m.start();
		wb({own, 1'b1}, 1'b0);
		rb(FILL_BYTE, 1'b0);
		rb(FILL_BYTE, 1'b1);
		m.stop();
		flt();
		lax = 1'b1;
		m.start();
		wb({own, 1'b1}, 1'b0);
		rb(FILL_BYTE, 1'b1);
		m.stop();
		flt();
		// standard rate general call
		m.half_ns = 5000;
		m.start();
		wb({GCALL_ADDR, 1'b0}, 1'b0);
		wb(8'h01, 1'b0);
		wd(1);
		evq.push_back(EV_DONE);
		m.stop();
		settle();
		m.half_ns = 600;
		// fill the fifo with the core stalled, expect a stretch
		pop_en = 1'b0;
		m.start();
		wb({own, 1'b0}, 1'b0);
		wb(8'hD0, 1'b0);
		fork
			wd(33);
			begin
				k = 0;
				while (scl_oe !== 1'b1 && k < 40000) begin
					@(posedge sys_clk);
					k++;
				end
				repeat (100) @(posedge sys_clk);
				chk("stretch", 8'h01, {7'h00, scl_oe});
				pop_en = 1'b1;
			end
		join
		evq.push_back(EV_DONE);
		m.stop();
		settle();
		m.half_ns = 1250;
		// clock parked low: abort, lines freed, new start accepted
		m.start();
		wb({own, 1'b0}, 1'b0);
		evq.push_back(EV_ABORT);
		repeat (TO * 7 / 5) @(posedge sys_clk);
		chk("scl_oe", 8'h00, {7'h00, scl_oe});
		chk("sda_oe", 8'h00, {7'h00, sda_oe});
		m.stop();
		settle();
		m.start();
		wb({own, 1'b0}, 1'b0);
		wb(8'h03, 1'b0);
		evq.push_back(EV_DONE);
		m.stop();
		settle();
		end_sim();
	end
endmodule
